// [verilog/fsl_pkg.sv]
package fsl_pkg;
    // clock and pattern times
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int unsigned ON_LONG_MS = 200;
    localparam int unsigned OFF_LONG_MS = 1000;
    localparam int unsigned FLICK_MS = 50;
    localparam int unsigned ACT_MS = 50;
    // network states
    localparam logic [3:0] ST_INIT = 4'h1;
    localparam logic [3:0] ST_PREOP = 4'h2;
    localparam logic [3:0] ST_BOOT = 4'h3;
    localparam logic [3:0] ST_SAFEOP = 4'h4;
    localparam logic [3:0] ST_OP = 4'h8;
    localparam logic [7:0] CHG_ERR = 8'h01;
    // APB map
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam logic [11:0] OFF_IRQ = 12'h008;
    localparam logic [11:0] OFF_MASK = 12'h00C;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam int unsigned CTRL_FORCE_OFF = 0;
    localparam int unsigned CTRL_LAMP_TEST = 1;
    localparam int unsigned IRQ_W = 4;
    // lamp patterns
    typedef enum logic [2:0] {
        FSL_OFF, FSL_ON, FSL_BLINK, FSL_FLICK, FSL_SFLASH, FSL_DFLASH
    } fsl_pat_t;
    // status inputs grouped
    typedef struct packed {
        logic link_ok;
        logic traffic;
        logic [3:0] net_state;
        logic booting;
        logic fw_download;
        logic pdi_wdog;
        logic app_wdog;
        logic cfg_err;
        logic local_change;
        logic [7:0] change_code;
    } fsl_stat_t;
endpackage

// [verilog/fsl_led_driver.sv]
`timescale 1ns/10ps
// Notes on behaviour
// R1 - link lamp steady on with valid idle link, dark without link
// R2 - link lamp flickers while link valid and traffic passes
// R3 - green state lamp steady on in OPERATIONAL
// R4 - PRE-OPERATIONAL blinks green 200 ms on, 200 ms off
// R5 - SAFE-OPERATIONAL single flash green: 200 ms on, 1000 ms off
// R6 - green flickers 50/50 ms when booting, bootstrap or downloading
// R7 - green state lamp dark in INIT
// R8 - red steady on after process-data watchdog timeout
// R9 - red blinks 200/200 ms on configuration error
// R10 - red flickers 50/50 ms when INIT reached with change code 0x01
// R11 - red single flash on autonomous local state change with change code 0x01
// R12 - red double flash on application watchdog timeout
// R13 - one millisecond tick times all; pattern restarts lit on change
// R14 - one red pattern by fixed priority, watchdogs above config errors
module fsl_led_driver #(
    parameter int unsigned MS_CYCLES = fsl_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // status inputs
    input wire fsl_pkg::fsl_stat_t stat,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // lamps and interrupt
    output logic link_traffic_lamp,
    output logic state_lamp,
    output logic error_lamp,
    output logic irq
);
    localparam int CW = $clog2(MS_CYCLES + 1);
    localparam logic [10:0] L_ON = 11'(fsl_pkg::ON_LONG_MS);
    localparam logic [10:0] L_OFF = 11'(fsl_pkg::OFF_LONG_MS);
    localparam logic [10:0] L_FL = 11'(fsl_pkg::FLICK_MS);
    localparam logic [10:0] L_ACT = 11'(fsl_pkg::ACT_MS);

    logic [CW-1:0] pre_reg;
    logic ms_tick;
    logic [31:0] ctrl_reg;
    logic [3:0] irq_reg;
    logic [3:0] mask_reg;
    logic [3:0] ev;
    logic [3:0] prev_reg;
    fsl_pkg::fsl_pat_t g_pat;
    fsl_pkg::fsl_pat_t r_pat;
    fsl_pkg::fsl_pat_t l_pat;
    fsl_pkg::fsl_pat_t pat_reg [3];
    logic [10:0] cnt_reg [3];
    logic [1:0] ph_reg [3];
    logic lit [3];
    logic wr;
    logic rd;

    // millisecond time base shared by all lamps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= '0;
        end else if (clk_en) begin
            if (pre_reg == CW'(MS_CYCLES - 1)) begin
                pre_reg <= '0;
            end else begin
                pre_reg <= pre_reg + CW'(1);
            end
        end
    end
    assign ms_tick = (pre_reg == CW'(MS_CYCLES - 1)); // [R13]

    // link lamp pattern select
    always_comb begin
        if (!stat.link_ok) begin
            l_pat = fsl_pkg::FSL_OFF; // [R1]
        end else if (stat.traffic) begin
            l_pat = fsl_pkg::FSL_FLICK; // [R2]
        end else begin
            l_pat = fsl_pkg::FSL_ON; // [R1]
        end
    end

    // green state lamp pattern select
    always_comb begin
        if (stat.booting || stat.fw_download ||
                stat.net_state == fsl_pkg::ST_BOOT) begin
            g_pat = fsl_pkg::FSL_FLICK; // [R6]
        end else begin
            case (stat.net_state)
                fsl_pkg::ST_OP: g_pat = fsl_pkg::FSL_ON; // [R3]
                fsl_pkg::ST_PREOP: g_pat = fsl_pkg::FSL_BLINK; // [R4]
                fsl_pkg::ST_SAFEOP: g_pat = fsl_pkg::FSL_SFLASH; // [R5]
                fsl_pkg::ST_INIT: g_pat = fsl_pkg::FSL_OFF; // [R7]
                default: g_pat = fsl_pkg::FSL_OFF;
            endcase
        end
    end

    // red lamp: one pattern by fixed priority
    always_comb begin
        if (stat.pdi_wdog) begin
            r_pat = fsl_pkg::FSL_ON; // [R8] [R14]
        end else if (stat.app_wdog) begin
            r_pat = fsl_pkg::FSL_DFLASH; // [R12] [R14]
        end else if (stat.net_state == fsl_pkg::ST_INIT &&
                stat.change_code == fsl_pkg::CHG_ERR) begin
            r_pat = fsl_pkg::FSL_FLICK; // [R10]
        end else if (stat.local_change &&
                stat.change_code == fsl_pkg::CHG_ERR) begin
            r_pat = fsl_pkg::FSL_SFLASH; // [R11]
        end else if (stat.cfg_err) begin
            r_pat = fsl_pkg::FSL_BLINK; // [R9] [R14]
        end else begin
            r_pat = fsl_pkg::FSL_OFF;
        end
    end

    // per lamp pattern sequencer: 0 link, 1 green, 2 red
    for (genvar i = 0; i < 3; i++) begin : g_lamp
        fsl_pkg::fsl_pat_t sel;
        logic [10:0] len;
        logic [1:0] last;
        assign sel = (i == 0) ? l_pat : (i == 1) ? g_pat : r_pat;
        // phase length and last phase of the registered pattern
        always_comb begin
            len = L_ON;
            last = 2'h1;
            case (pat_reg[i])
                fsl_pkg::FSL_FLICK: len = (i == 0) ? L_ACT : L_FL;
                fsl_pkg::FSL_BLINK: len = L_ON;
                fsl_pkg::FSL_SFLASH: len = ph_reg[i][0] ? L_OFF : L_ON;
                fsl_pkg::FSL_DFLASH: begin
                    len = (ph_reg[i] == 2'h3) ? L_OFF : L_ON;
                    last = 2'h3;
                end
                default: len = L_ON;
            endcase
        end
        // even phases lit, odd phases dark; steady on and off ignore the phase
        always_comb begin
            case (pat_reg[i])
                fsl_pkg::FSL_ON: lit[i] = 1'b1;
                fsl_pkg::FSL_OFF: lit[i] = 1'b0;
                default: lit[i] = ~ph_reg[i][0];
            endcase
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pat_reg[i] <= fsl_pkg::FSL_OFF;
                cnt_reg[i] <= '0;
                ph_reg[i] <= '0;
            end else if (clk_en) begin
                if (sel != pat_reg[i]) begin
                    pat_reg[i] <= sel; // restart lit [R13]
                    cnt_reg[i] <= '0;
                    ph_reg[i] <= '0;
                end else if (ms_tick) begin
                    if (cnt_reg[i] == len - 11'h001) begin
                        cnt_reg[i] <= '0; // [R4] [R5] [R6] [R12]
                        ph_reg[i] <= (ph_reg[i] == last) ? 2'h0 :
                            ph_reg[i] + 2'h1;
                    end else begin
                        cnt_reg[i] <= cnt_reg[i] + 11'h001;
                    end
                end
            end
        end
    end

    // lamp outputs, with software override
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_traffic_lamp <= 1'b0;
            state_lamp <= 1'b0;
            error_lamp <= 1'b0;
        end else if (clk_en) begin
            if (ctrl_reg[fsl_pkg::CTRL_LAMP_TEST]) begin
                link_traffic_lamp <= 1'b1;
                state_lamp <= 1'b1;
                error_lamp <= 1'b1;
            end else if (ctrl_reg[fsl_pkg::CTRL_FORCE_OFF]) begin
                link_traffic_lamp <= 1'b0;
                state_lamp <= 1'b0;
                error_lamp <= 1'b0;
            end else begin
                link_traffic_lamp <= lit[0]; // [R1] [R2]
                state_lamp <= lit[1]; // [R3] [R7]
                error_lamp <= lit[2]; // [R8]
            end
        end
    end

    // apb decode, zero wait
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign ev = {stat.app_wdog, stat.pdi_wdog, stat.cfg_err,
        stat.link_ok} & ~prev_reg;

    // control and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= fsl_pkg::CTRL_RST;
            mask_reg <= fsl_pkg::MASK_RST;
        end else if (clk_en && wr) begin
            if (paddr == fsl_pkg::OFF_CTRL) begin
                ctrl_reg <= pwdata;
            end
            if (paddr == fsl_pkg::OFF_MASK) begin
                mask_reg <= pwdata[3:0];
            end
        end
    end

    // sticky events, cleared by read, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= '0;
            irq_reg <= '0;
            irq <= 1'b0;
        end else if (clk_en) begin
            prev_reg <= {stat.app_wdog, stat.pdi_wdog, stat.cfg_err,
                stat.link_ok};
            // clear only the bits already shown in the read data
            if (rd && paddr == fsl_pkg::OFF_IRQ) begin
                irq_reg <= (irq_reg & ~prdata[3:0]) | ev;
            end else begin
                irq_reg <= irq_reg | ev;
            end
            irq <= |(((rd && paddr == fsl_pkg::OFF_IRQ) ?
                ((irq_reg & ~prdata[3:0]) | ev) : (irq_reg | ev)) & mask_reg);
        end
    end

    // read data and answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != fsl_pkg::OFF_CTRL &&
                paddr != fsl_pkg::OFF_STAT && paddr != fsl_pkg::OFF_IRQ &&
                paddr != fsl_pkg::OFF_MASK;
            case (paddr)
                fsl_pkg::OFF_CTRL: prdata <= ctrl_reg;
                fsl_pkg::OFF_STAT: prdata <= {25'h0000000, error_lamp,
                    state_lamp, link_traffic_lamp, stat.net_state};
                fsl_pkg::OFF_IRQ: prdata <= {28'h0000000, irq_reg};
                fsl_pkg::OFF_MASK: prdata <= {28'h0000000, mask_reg};
                default: prdata <= '0;
            endcase
        end
    end
endmodule // fsl_led_driver

// [sim/fsl_led_driver_props.sv]
`timescale 1ns/10ps
module fsl_led_driver_props #(
    parameter int unsigned MS_CYCLES = 10
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // status and bus
    input wire fsl_pkg::fsl_stat_t stat,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // lamps and interrupt
    input wire logic link_traffic_lamp,
    input wire logic state_lamp,
    input wire logic error_lamp,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !clk_en);
    // setup phase and plain green selections
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_op;
        !stat.booting && !stat.fw_download && stat.net_state == fsl_pkg::ST_OP;
    endsequence
    sequence s_init;
        !stat.booting && !stat.fw_download
            && stat.net_state == fsl_pkg::ST_INIT;
    endsequence
    AST_ANSWER: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held");
    AST_ERR_ON_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_LINK_DARK: assert property (
        !stat.link_ok [*3] |-> !link_traffic_lamp) else $error("link lit");
    AST_LINK_STEADY: assert property (
        (stat.link_ok && !stat.traffic) [*3] |-> link_traffic_lamp)
        else $error("idle link dark");
    AST_GREEN_OP: assert property (s_op [*3] |-> state_lamp)
        else $error("green dark when operational");
    AST_GREEN_INIT: assert property (s_init [*3] |-> !state_lamp)
        else $error("green lit in init");
    AST_RED_PDI: assert property (stat.pdi_wdog [*3] |-> error_lamp)
        else $error("red dark on watchdog");
endmodule // fsl_led_driver_props

bind fsl_led_driver fsl_led_driver_props #(.MS_CYCLES(MS_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .stat(stat),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_traffic_lamp(link_traffic_lamp), .state_lamp(state_lamp),
    .error_lamp(error_lamp), .irq(irq));

// [sim/fsl_lamp_model.sv]
`timescale 1ns/10ps
module fsl_lamp_model (
    // lamp at the connector
    input wire logic pclk,
    input wire logic lamp,
    // last lit and dark run lengths in cycles
    output int on_len,
    output int off_len,
    output int off_prev
);
    int run = 0;
    logic last = 1'b0;
    // time each steady run of the lamp
    always @(posedge pclk) begin
        if (lamp !== last) begin
            if (last) on_len <= run;
            else off_prev <= off_len;
            if (!last) off_len <= run;
            run <= 1;
        end else run <= run + 1;
        last <= lamp;
    end
endmodule // fsl_lamp_model

// [sim/fsl_led_driver_tb.sv]
`timescale 1ns/10ps
module fsl_led_driver_tb;
    localparam int MS = 4;
    localparam int FL = fsl_pkg::FLICK_MS * MS;
    localparam int LG = fsl_pkg::ON_LONG_MS * MS;
    localparam int SL = fsl_pkg::OFF_LONG_MS * MS;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, link_traffic_lamp, state_lamp, error_lamp, irq, er;
    fsl_pkg::fsl_stat_t st = '0;
    fsl_pkg::fsl_stat_t nx = '0;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    int on_l[3], off_l[3], offp_l[3];
    // clock and timeout
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 50000) begin
            mismatches++;
            report_and_stop;
        end
    end
    fsl_led_driver #(.MS_CYCLES(MS)) u_fsl_led_driver (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .stat(st),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_traffic_lamp(link_traffic_lamp), .state_lamp(state_lamp),
        .error_lamp(error_lamp), .irq(irq));
    fsl_lamp_model u_lk (.pclk(pclk), .lamp(link_traffic_lamp),
        .on_len(on_l[0]), .off_len(off_l[0]), .off_prev(offp_l[0]));
    fsl_lamp_model u_gr (.pclk(pclk), .lamp(state_lamp),
        .on_len(on_l[1]), .off_len(off_l[1]), .off_prev(offp_l[1]));
    fsl_lamp_model u_rd (.pclk(pclk), .lamp(error_lamp),
        .on_len(on_l[2]), .off_len(off_l[2]), .off_prev(offp_l[2]));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic put(input int n);
        @(posedge pclk);
        st <= nx;
        tick(n);
    endtask
    task automatic pat(input int i, input int on, input int off);
        chk(on_l[i], on);
        chk(off_l[i], off);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            mismatches++;
            report_and_stop;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_regs;
        apb(1'b0, fsl_pkg::OFF_MASK, 32'h0);
        chk(rd, {28'h0, fsl_pkg::MASK_RST});
        apb(1'b1, fsl_pkg::OFF_MASK, 32'h0000_000F);
        apb(1'b0, fsl_pkg::OFF_MASK, 32'h0);
        chk(rd, 32'h0000_000F);
        apb(1'b0, fsl_pkg::OFF_CTRL, 32'h0);
        chk(rd, fsl_pkg::CTRL_RST);
        apb(1'b1, fsl_pkg::OFF_CTRL, 32'h0000_0001);
        apb(1'b0, fsl_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h0000_0001);
        chk(32'(link_traffic_lamp), 32'h0);
        apb(1'b1, fsl_pkg::OFF_CTRL, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
    endtask
    task automatic t_link;
        put(4);
        chk(32'(link_traffic_lamp), 32'h0);
        nx.link_ok = 1'b1;
        put(4);
        chk(32'(link_traffic_lamp), 32'h1);
        apb(1'b0, fsl_pkg::OFF_STAT, 32'h0);
        chk(rd, 32'h0000_0010);
        // frozen clock enable holds the lamp
        @(posedge pclk);
        clk_en <= 1'b0;
        nx.link_ok = 1'b0;
        put(8);
        chk(32'(link_traffic_lamp), 32'h1);
        nx.link_ok = 1'b1;
        put(2);
        clk_en <= 1'b1;
        tick(4);
        chk(32'(link_traffic_lamp), 32'h1);
        nx.traffic = 1'b1;
        put(6 * FL);
        pat(0, FL, FL);
        nx.traffic = 1'b0;
        put(2);
    endtask
    task automatic t_green;
        nx.net_state = fsl_pkg::ST_OP;
        put(4);
        chk(32'(state_lamp), 32'h1);
        for (int k = 0; k < 3; k++) begin
            nx.net_state = fsl_pkg::ST_INIT;
            nx.booting = 1'b0;
            nx.fw_download = 1'b0;
            put(4);
            chk(32'(state_lamp), 32'h0);
            nx.net_state = (k == 0) ? fsl_pkg::ST_BOOT : fsl_pkg::ST_INIT;
            nx.booting = (k == 1);
            nx.fw_download = (k == 2);
            put(6 * FL);
            pat(1, FL, FL);
        end
        nx.booting = 1'b0;
        nx.fw_download = 1'b0;
    endtask
    task automatic t_red;
        apb(1'b0, fsl_pkg::OFF_IRQ, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, fsl_pkg::OFF_MASK, 32'h0000_0002);
        nx.pdi_wdog = 1'b1;
        put(4);
        chk(32'(error_lamp), 32'h1);
        chk(32'(irq), 32'h0);
        nx.app_wdog = 1'b1;
        put(LG + 4);
        chk(32'(error_lamp), 32'h1);
        nx.pdi_wdog = 1'b0;
        nx.app_wdog = 1'b0;
        nx.cfg_err = 1'b1;
        put(4);
        chk(32'(irq), 32'h1);
        apb(1'b0, fsl_pkg::OFF_IRQ, 32'h0);
        chk(rd, 32'h0000_000E);
        tick(3);
        chk(32'(irq), 32'h0);
        tick(6 * LG);
        pat(2, LG, LG);
        nx.app_wdog = 1'b1;
        nx.net_state = fsl_pkg::ST_PREOP;
        put(3);
        chk(32'(error_lamp), 32'h1);
        tick(2 * (3 * LG + SL));
        chk(on_l[2], LG);
        chk(off_l[2] + offp_l[2], LG + SL);
        pat(1, LG, LG);
        nx.app_wdog = 1'b0;
        nx.cfg_err = 1'b0;
        nx.net_state = fsl_pkg::ST_INIT;
        nx.change_code = fsl_pkg::CHG_ERR;
        put(6 * FL);
        pat(2, FL, FL);
        nx.net_state = fsl_pkg::ST_SAFEOP;
        nx.local_change = 1'b1;
        put(2 * (LG + SL) + 8);
        pat(2, LG, SL);
        pat(1, LG, SL);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial begin
        tick(12);
        presetn <= 1'b1;
        t_regs;
        t_link;
        t_green;
        t_red;
        report_and_stop;
    end
endmodule // fsl_led_driver_tb
